/* design/sif_port.sv */
// Sixteen-channel filtered digital input port with cyclic and acyclic access
`timescale 1ns/1ps
module sif_port #(
    parameter int CHANNELS = 16,
    parameter int SAMPLE_CYCLES = sif_pkg::SAMPLE_CYCLES,
    parameter int LED_BASE_CYCLES = sif_pkg::LED_BASE_CYCLES
) (
    input wire logic core_clk_i,        // System clock, 40 MHz
    input wire logic rst_b_i,           // Async reset, active low
    input wire logic [15:0] din_i,      // Input pins, asynchronous
    input wire logic cyc_rd_i,          // Cyclic read strobe
    input wire logic [1:0] cyc_off_i,   // Cyclic frame offset
    input wire logic packed_mode_i,     // High: packed word at offset 1
    output logic [15:0] cyc_data_o,     // Cyclic read data
    output logic cyc_valid_o,           // Cyclic answer pulse
    output logic cyc_err_o,             // Cyclic offset not mapped
    input wire logic acyc_req_i,        // Acyclic request strobe
    input wire logic acyc_we_i,         // Acyclic write when high
    input wire logic [7:0] acyc_num_i,  // Acyclic register number
    input wire logic [7:0] acyc_wdata_i, // Acyclic write data
    output logic [7:0] acyc_rdata_o,    // Acyclic read data
    output logic acyc_ack_o,            // Acyclic answer pulse
    output logic acyc_err_o,            // Acyclic access refused
    input wire logic power_ok_i,        // Module supply present
    input wire logic fw_valid_i,        // Firmware image valid
    input wire logic fault_i,           // Module fault pending
    input wire logic [2:0] mode_i,      // Operating mode, one-hot
    output logic led_status_green_o,    // Module status LED, green
    output logic led_status_red_o,      // Module status LED, red
    output logic [15:0] led_chan_o,     // Channel LEDs, green
    output logic [7:0] filter_delay_o   // Active filter delay, 100 us units
);
    localparam int SMP_W = $clog2(SAMPLE_CYCLES + 1);
    localparam int LED_W = $clog2(LED_BASE_CYCLES + 1);

    // Channel count is fixed by the register layout; timing counts must be non-zero
    if (CHANNELS != 16 || SAMPLE_CYCLES < 1 || LED_BASE_CYCLES < 1) begin : g_bad_params
        $error("sif_port: unsupported parameter values");
    end

    typedef struct packed {
        logic [15:0] sync1;
        logic [15:0] sync2;
        logic [SMP_W-1:0] smp_cnt;
        logic smp_tick;
        logic [7:0] delay;
        logic [LED_W-1:0] led_cnt;
        logic [4:0] led_phase;
        logic [15:0] cyc_data;
        logic cyc_valid;
        logic cyc_err;
        logic [7:0] acyc_rdata;
        logic acyc_ack;
        logic acyc_err;
        logic led_green;
        logic led_red;
        logic [15:0] led_chan;
    } sif_port_s;

    sif_port_s st_r;
    sif_port_s st_nxt;

    logic [15:0] filt;
    logic [8:0] need_wide;
    logic [7:0] need;
    logic bypass;

    // Two 100 us steps per sample, so the needed count rounds up
    assign need_wide = {1'b0, st_r.delay} + 9'h001;
    assign need = need_wide[8:1];
    assign bypass = (st_r.delay == sif_pkg::FILTER_DELAY_OFF);

    genvar g;
    generate
        for (g = 0; g < CHANNELS; g = g + 1) begin : g_chan
            // Independent filter per channel
            sif_filter u_filter (
                .core_clk_i(core_clk_i),
                .rst_b_i(rst_b_i),
                .raw_i(st_r.sync2[g]),
                .sample_tick_i(st_r.smp_tick),
                .bypass_i(bypass),
                .need_i(need),
                .state_o(filt[g])
            );
        end
    endgenerate

    always_comb begin
        st_nxt = st_r;
        st_nxt.sync1 = din_i;
        st_nxt.sync2 = st_r.sync1;

        // Free-running sample tick, not tied to the bus cycle
        st_nxt.smp_tick = 1'b0;
        if (st_r.smp_cnt == SMP_W'(SAMPLE_CYCLES - 1)) begin
            st_nxt.smp_cnt = '0;
            st_nxt.smp_tick = 1'b1;
        end else begin
            st_nxt.smp_cnt = st_r.smp_cnt + SMP_W'(1);
        end

        // Cyclic port addresses by frame offset and packed_mode_i
        st_nxt.cyc_valid = cyc_rd_i;
        st_nxt.cyc_err = 1'b0;
        if (cyc_rd_i) begin
            st_nxt.cyc_data = 16'h0000;
            if (packed_mode_i && cyc_off_i == sif_pkg::CYC_OFF_PACKED) begin
                st_nxt.cyc_data = filt;
            end else if (!packed_mode_i && cyc_off_i == sif_pkg::CYC_OFF_LOW) begin
                st_nxt.cyc_data = {8'h00, filt[7:0]};
            end else if (!packed_mode_i && cyc_off_i == sif_pkg::CYC_OFF_HIGH) begin
                st_nxt.cyc_data = {8'h00, filt[15:8]};
            end else begin
                st_nxt.cyc_err = 1'b1;
            end
        end

        // Acyclic port addresses by register number
        st_nxt.acyc_ack = acyc_req_i;
        st_nxt.acyc_err = 1'b0;
        if (acyc_req_i) begin
            st_nxt.acyc_rdata = 8'h00;
            if (acyc_we_i && acyc_num_i == sif_pkg::REG_FILTER_DELAY) begin
                // Clamp oversize values
                if (acyc_wdata_i > sif_pkg::FILTER_DELAY_MAX) begin
                    st_nxt.delay = sif_pkg::FILTER_DELAY_MAX;
                end else begin
                    st_nxt.delay = acyc_wdata_i;
                end
            end else begin
                // Status is cyclic-read only and the delay is write only
                st_nxt.acyc_err = 1'b1;
            end
        end

        // LED pattern time base
        if (st_r.led_cnt == LED_W'(LED_BASE_CYCLES - 1)) begin
            st_nxt.led_cnt = '0;
            if (st_r.led_phase == sif_pkg::LED_FRAME_PHASES - 5'h01) begin
                st_nxt.led_phase = 5'h00;
            end else begin
                st_nxt.led_phase = st_r.led_phase + 5'h01;
            end
        end else begin
            st_nxt.led_cnt = st_r.led_cnt + LED_W'(1);
        end

        st_nxt.led_chan = filt;
        st_nxt.led_red = 1'b0;
        st_nxt.led_green = 1'b0;
        if (!power_ok_i) begin
            // Unpowered module shows nothing
            st_nxt.led_chan = 16'h0000;
        end else if (!fw_valid_i) begin
            st_nxt.led_red = 1'b1;
            st_nxt.led_green = (st_r.led_phase < sif_pkg::LED_FLASH_PHASES);
        end else begin
            st_nxt.led_red = fault_i;
            unique case (mode_i)
                sif_pkg::SIF_MODE_RESET: begin
                    st_nxt.led_green = (st_r.led_phase < sif_pkg::LED_FLASH_PHASES);
                end
                sif_pkg::SIF_MODE_PREOP: begin
                    st_nxt.led_green = (st_r.led_phase[2:0] < sif_pkg::LED_BLINK_PHASES);
                end
                sif_pkg::SIF_MODE_RUN: begin
                    st_nxt.led_green = 1'b1;
                end
                default: begin
                    // Illegal mode code from firmware: keep the green LED dark
                    st_nxt.led_green = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_r <= '0;
            st_r.delay <= sif_pkg::FILTER_DELAY_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign cyc_data_o = st_r.cyc_data;
    assign cyc_valid_o = st_r.cyc_valid;
    assign cyc_err_o = st_r.cyc_err;
    assign acyc_rdata_o = st_r.acyc_rdata;
    assign acyc_ack_o = st_r.acyc_ack;
    assign acyc_err_o = st_r.acyc_err;
    assign led_status_green_o = st_r.led_green;
    assign led_status_red_o = st_r.led_red;
    assign led_chan_o = st_r.led_chan;
    assign filter_delay_o = st_r.delay;
endmodule

/* design/sif_pkg.sv */
// Shared constants and types for the sixteen-channel filtered input port
package sif_pkg;
    // Timing base and sampling interval
    localparam int CLK_KHZ = 40000;
    localparam int SAMPLE_PERIOD_US = 200;
    localparam int SAMPLE_CYCLES = SAMPLE_PERIOD_US * CLK_KHZ / 1000;
    localparam int LED_BASE_MS = 50;
    localparam int LED_BASE_CYCLES = LED_BASE_MS * CLK_KHZ;

    // LED pattern in 50 ms phases: one frame lasts 24 phases (1.2 s)
    localparam logic [4:0] LED_FRAME_PHASES = 5'h18;
    localparam logic [4:0] LED_FLASH_PHASES = 5'h04;
    localparam logic [2:0] LED_BLINK_PHASES = 3'h4;

    // Acyclic register numbers
    localparam logic [7:0] REG_INPUTS_LOW = 8'h00;
    localparam logic [7:0] REG_INPUTS_HIGH = 8'h01;
    localparam logic [7:0] REG_FILTER_DELAY = 8'h12;

    // Cyclic frame offsets
    localparam logic [1:0] CYC_OFF_PACKED = 2'h1;
    localparam logic [1:0] CYC_OFF_LOW = 2'h1;
    localparam logic [1:0] CYC_OFF_HIGH = 2'h2;

    // Filter delay field, units of 100 us
    localparam logic [7:0] FILTER_DELAY_MAX = 8'hFA;
    localparam logic [7:0] FILTER_DELAY_RESET = 8'h0A;
    localparam logic [7:0] FILTER_DELAY_OFF = 8'h00;

    // Operating mode reported by the module firmware
    typedef enum logic [2:0] {
        SIF_MODE_RESET = 3'b001,
        SIF_MODE_PREOP = 3'b010,
        SIF_MODE_RUN = 3'b100
    } sif_mode_e;
endpackage

/* design/sif_filter.sv */
// One input channel glitch filter working on the shared sample tick
`timescale 1ns/1ps
module sif_filter (
    input wire logic core_clk_i,      // System clock
    input wire logic rst_b_i,         // Async reset, active low
    input wire logic raw_i,           // Synchronised input level
    input wire logic sample_tick_i,   // One-cycle pulse every sample period
    input wire logic bypass_i,        // High when filtering is disabled
    input wire logic [7:0] need_i,    // Stable samples needed to accept a change
    output logic state_o              // Filtered channel state
);
    typedef struct packed {
        logic state;
        logic [7:0] cnt;
    } sif_filter_s;

    sif_filter_s st_r;
    sif_filter_s st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (bypass_i) begin
            st_nxt.state = raw_i;
            st_nxt.cnt = 8'h00;
        end else if (sample_tick_i) begin
            // A differing level must persist for need_i samples
            if (raw_i == st_r.state) begin
                st_nxt.cnt = 8'h00;
            end else if ((st_r.cnt + 8'h01) >= need_i) begin
                st_nxt.state = raw_i;
                st_nxt.cnt = 8'h00;
            end else begin
                st_nxt.cnt = st_r.cnt + 8'h01;
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign state_o = st_r.state;
endmodule

/* dv/sif_port_checker.sv */
// Port-level assertions for the filtered input port
`timescale 1ns/1ps
module sif_port_checker (
    input wire logic core_clk_i, // Clock
    input wire logic rst_b_i, // Reset
    input wire logic cyc_rd_i, // Read
    input wire logic [1:0] cyc_off_i, // Offset
    input wire logic packed_mode_i, // Packed
    input wire logic [15:0] cyc_data_o, // Data
    input wire logic cyc_valid_o, // Valid
    input wire logic cyc_err_o, // Error
    input wire logic acyc_req_i, // Request
    input wire logic acyc_we_i, // Write
    input wire logic [7:0] acyc_num_i, // Number
    input wire logic [7:0] acyc_wdata_i, // Wdata
    input wire logic acyc_ack_o, // Ack
    input wire logic acyc_err_o, // Refused
    input wire logic power_ok_i, // Supply
    input wire logic fw_valid_i, // Firmware
    input wire logic fault_i, // Fault
    input wire logic [2:0] mode_i, // Mode
    input wire logic led_status_green_o, // Green
    input wire logic led_status_red_o, // Red
    input wire logic [15:0] led_chan_o, // Channels
    input wire logic [7:0] filter_delay_o // Delay
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_b_i);
    sequence s_cyc(o, p); cyc_rd_i && cyc_off_i == o && packed_mode_i == p; endsequence
    sequence s_set; acyc_req_i && acyc_we_i && acyc_num_i == 8'h12; endsequence
    property p_ans; cyc_rd_i |=> cyc_valid_o; endproperty
    a_ans: assert property (p_ans) else $error("no cyclic answer");
    property p_word; s_cyc(2'h1, 1'b1) ##0 power_ok_i |=> cyc_data_o == led_chan_o; endproperty
    a_word: assert property (p_word) else $error("packed word wrong");
    property p_unmap; s_cyc(2'h0, 1'b1) |=> cyc_err_o && cyc_data_o == 16'h0000; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped offset taken");
    property p_refuse; acyc_req_i && !(acyc_we_i && acyc_num_i == 8'h12)
        |=> acyc_ack_o && acyc_err_o && $stable(filter_delay_o); endproperty
    a_refuse: assert property (p_refuse) else $error("bad access accepted");
    property p_clamp; s_set |=> acyc_ack_o && filter_delay_o ==
        ($past(acyc_wdata_i) > 8'hFA ? 8'hFA : $past(acyc_wdata_i)); endproperty
    a_clamp: assert property (p_clamp) else $error("delay not stored");
    property p_red_off; !power_ok_i || (fw_valid_i && !fault_i) |=> !led_status_red_o; endproperty
    a_red_off: assert property (p_red_off) else $error("red lit");
    property p_red_fw; power_ok_i && !fw_valid_i |=> led_status_red_o; endproperty
    a_red_fw: assert property (p_red_fw) else $error("red dark");
    property p_run; power_ok_i && fw_valid_i && mode_i == 3'b100 |=> led_status_green_o; endproperty
    a_run: assert property (p_run) else $error("run green dark");
    property p_dark; !power_ok_i |=> !led_status_green_o && led_chan_o == 16'h0000; endproperty
    a_dark: assert property (p_dark) else $error("lit unpowered");
endmodule
bind sif_port sif_port_checker u_sif_port_checker (.*);

/* dv/sif_bus_ctrl.sv */
// Fieldbus controller model issuing cyclic reads and register writes
`timescale 1ns/1ps
module sif_bus_ctrl (
    input wire logic clk_i, // Clock
    output logic rd_o, // Cyclic read
    output logic [1:0] off_o, // Frame offset
    output logic req_o, // Acyclic request
    output logic we_o, // Write
    output logic [7:0] num_o, // Register number
    output logic [7:0] wd_o // Write data
);
    initial {rd_o, off_o, req_o, we_o, num_o, wd_o} = '0;
    task automatic cyc(input logic [1:0] o);
        @(negedge clk_i);
        rd_o = 1'b1;
        off_o = o;
        @(negedge clk_i);
        rd_o = 1'b0;
        off_o = ~o;
    endtask
    task automatic acyc(input logic w, input logic [7:0] n, input logic [7:0] d);
        @(negedge clk_i);
        req_o = 1'b1;
        {we_o, num_o, wd_o} = {w, n, d};
        @(negedge clk_i);
        req_o = 1'b0;
        {we_o, num_o, wd_o} = ~{w, n, d};
    endtask
endmodule

/* dv/sif_port_tb.sv */
// Self-checking bench for the filtered input port
`timescale 1ns/1ps
module sif_port_tb;
    logic core_clk_i, rst_b_i, cyc_rd_i, packed_mode_i, cyc_valid_o, cyc_err_o, acyc_req_i;
    logic acyc_we_i, acyc_ack_o, acyc_err_o, power_ok_i, fw_valid_i, fault_i;
    logic led_status_green_o, led_status_red_o;
    logic [1:0] cyc_off_i;
    logic [2:0] mode_i;
    logic [7:0] acyc_num_i, acyc_wdata_i, acyc_rdata_o, filter_delay_o;
    logic [15:0] din_i, cyc_data_o, led_chan_o;
    int fails, comparisons, ticks;
    // Short sample and LED steps keep the run brief
    sif_port #(.SAMPLE_CYCLES(4), .LED_BASE_CYCLES(2)) u_sif_port (.*);
    sif_bus_ctrl u_sif_bus_ctrl (.clk_i(core_clk_i), .rd_o(cyc_rd_i), .off_o(cyc_off_i),
        .req_o(acyc_req_i), .we_o(acyc_we_i), .num_o(acyc_num_i), .wd_o(acyc_wdata_i));
    initial begin
        core_clk_i = 1'b0;
        forever #12.5 core_clk_i = ~core_clk_i;
    end
    task automatic check(input logic [17:0] seen, input logic [17:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    always @(posedge core_clk_i) begin
        ticks++;
        if (ticks == 2000) begin
            fails++;
            conclude();
        end
    end
    task automatic wait_n(input int n);
        repeat (n) @(negedge core_clk_i);
    endtask
    task automatic t_delay();
        logic [7:0] v[3] = '{8'hFF, 8'hFA, 8'h00};
        check(filter_delay_o, 8'h0A);
        foreach (v[i]) begin
            u_sif_bus_ctrl.acyc(1'b1, 8'h12, v[i]);
            check({acyc_ack_o, acyc_err_o, filter_delay_o}, {2'b10, v[i] > 8'hFA ? 8'hFA : v[i]});
        end
        u_sif_bus_ctrl.acyc(1'b0, 8'h12, 8'h05);
        check({acyc_ack_o, acyc_err_o, acyc_rdata_o}, 10'h300);
        u_sif_bus_ctrl.acyc(1'b1, 8'h00, 8'h05);
        check({acyc_err_o, filter_delay_o}, 9'h100);
    endtask
    task automatic t_read();
        din_i = 16'hA5C3;
        wait_n(6);
        check(led_chan_o, 16'hA5C3);
        u_sif_bus_ctrl.cyc(2'h1);
        check({cyc_valid_o, cyc_err_o, cyc_data_o}, {2'b10, 16'hA5C3});
        u_sif_bus_ctrl.cyc(2'h2);
        check({cyc_valid_o, cyc_err_o, cyc_data_o}, {2'b11, 16'h0000});
        u_sif_bus_ctrl.cyc(2'h0);
        check({cyc_valid_o, cyc_err_o, cyc_data_o}, {2'b11, 16'h0000});
        packed_mode_i = 1'b0;
        u_sif_bus_ctrl.cyc(2'h3);
        check({cyc_valid_o, cyc_err_o, cyc_data_o}, {2'b11, 16'h0000});
        u_sif_bus_ctrl.cyc(2'h1);
        check(cyc_data_o[7:0], 8'hC3);
        u_sif_bus_ctrl.cyc(2'h2);
        check(cyc_data_o[7:0], 8'hA5);
    endtask
    task automatic t_glitch();
        u_sif_bus_ctrl.acyc(1'b1, 8'h12, 8'h04);
        din_i = ~din_i;
        wait_n(3);
        din_i = ~din_i;
        wait_n(20);
        check(led_chan_o, 16'hA5C3);
        din_i = 16'h5A3C;
        wait_n(30);
        check(led_chan_o, 16'h5A3C);
    endtask
    task automatic t_leds();
        logic [2:0] md[3] = '{3'b001, 3'b010, 3'b100};
        logic [17:0] ex[3] = '{18'h00008, 18'h00018, 18'h00030};
        logic [17:0] n;
        foreach (md[i]) begin
            mode_i = md[i];
            wait_n(2);
            n = '0;
            repeat (48) begin
                @(negedge core_clk_i);
                n += led_status_green_o;
            end
            check(n, ex[i]);
        end
        fault_i = 1'b1;
        wait_n(2);
        check(led_status_red_o, 1'b1);
        fault_i = 1'b0;
        wait_n(2);
        check(led_status_red_o, 1'b0);
        fw_valid_i = 1'b0;
        wait_n(2);
        check(led_status_red_o, 1'b1);
        power_ok_i = 1'b0;
        wait_n(3);
        check({led_status_green_o, led_status_red_o, led_chan_o}, 18'h0);
    endtask
    initial begin
        rst_b_i = 1'b0;
        din_i = 16'h0000;
        packed_mode_i = 1'b1;
        power_ok_i = 1'b1;
        fw_valid_i = 1'b1;
        fault_i = 1'b0;
        mode_i = 3'b100;
        wait_n(20);
        rst_b_i = 1'b1;
        t_delay();
        t_read();
        t_glitch();
        t_leds();
        conclude();
    end
endmodule
